// ---- line_unit_pkg.sv ----
/*
 Line unit test pattern and control package: register indices, field
 positions, reset values, test pattern codes and timing counts.
 Assumes a 10 MHz core clock and an AHB-Lite register bus, 32-bit data.
*/
// Functional notes
// - Pattern kind bit picks random sequence: 0 is 2^15-1, 1 is 2^20-1.
// - Direction bit sends random output to line when 0, receive outputs when 1.
// - Receiver-on clear powers down receive section except clock PLL; set accepts data.
// - Five-bit equalizer field, reset zero, selects pulse shape, build-out, sensitivity.
// - Equalizer codes 0x00-0x17 are T1, 0x18-0x1F are E1 coax or pair.
// - Arbitrary pulse mode takes amplitude from eight segment registers in channel range.
// - Receiver input high impedance after reset; termination bit 1 enables internal.
// - Jitter attenuator enable bits insert it in transmit and receive paths.
// - Invert bit inverts the generated random pattern when 1.
// - Three-bit test field, reset 000: 0xx none, 100 random, 101 ones, 110 up, 111 down.
// - Any test selection 1xx forces line unit and framer into single rail.
// - Loop-up mode sends the network loop-up code repeatedly.
// - While sending loop-up, own loop-code detection and remote loop-back are ignored.
// - Loop-up code is repeating 00001.
// - Loop-down code is repeating 001.
`default_nettype none
package line_unit_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL_TWO = 16'h0E02;
   localparam logic [15:0] IDX_CTRL_ZERO = 16'h0F00;
   localparam logic [15:0] IDX_CTRL_ONE = 16'h0F01;
   localparam logic [15:0] IDX_SEG_BASE = 16'h0F08;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 17;

   // Reset values
   localparam logic [7:0] RST_CTRL_ZERO = 8'h00;
   localparam logic [7:0] RST_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'h00;
   localparam logic [7:0] RST_SEGMENT = 8'h00;

   // Control zero fields
   localparam int F0_KIND = 7;
   localparam int F0_DIRECTION = 6;
   localparam int F0_RX_ON = 5;
   localparam int F0_EQ_MSB = 4;
   localparam int F0_EQ_LSB = 0;

   // Control one fields
   localparam int F1_RX_TERM = 7;
   localparam int F1_TX_TERM = 6;
   localparam int F1_IMP_MSB = 5;
   localparam int F1_IMP_LSB = 4;
   localparam int F1_RX_JA = 3;
   localparam int F1_TX_JA = 2;
   localparam int F1_JA_BW = 1;
   localparam int F1_FIFO_SIZE = 0;

   // Control two fields
   localparam int F2_INVERT = 7;
   localparam int F2_TEST_MSB = 6;
   localparam int F2_TEST_LSB = 4;

   // Equalizer code boundaries
   localparam logic [4:0] EQ_FIRST_E1 = 5'h18;
   localparam logic [4:0] EQ_T1_SH_ARB = 5'h0D;
   localparam logic [4:0] EQ_T1_GAIN_ARB = 5'h13;

   // Transmit test selections
   typedef enum logic [2:0] {
      TEST_NONE = 3'b000,
      TEST_RANDOM = 3'b100,
      TEST_ONES = 3'b101,
      TEST_LOOP_UP = 3'b110,
      TEST_LOOP_DOWN = 3'b111
   } test_sel_e;

   // Sequence lengths and taps
   localparam logic [2:0] LOOP_UP_LEN = 3'h5;
   localparam logic [2:0] LOOP_DOWN_LEN = 3'h3;
   localparam int PRBS_TAP_A = 14;
   localparam int PRBS_TAP_B = 13;
   localparam int QRSS_TAP_A = 19;
   localparam int QRSS_TAP_B = 16;
   localparam logic [19:0] LFSR_SEED = 20'h00001;

   // Line bit rate divider from the core clock
   localparam int BIT_DIV = 5;

endpackage
`default_nettype wire

// ---- test_pattern_gen.sv ----
/*
 Transmit test pattern generator: pseudo-random, quasi-random, all ones,
 loop-up and loop-down codes, one bit per line bit tick.
 Assumes the tick is a one-cycle enable on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pattern_gen (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_tick,
   input wire logic [2:0] i_test_sel,
   input wire logic i_kind,
   input wire logic i_invert,
   output logic o_pattern_bit
);
   import line_unit_pkg::*;

   typedef struct packed {
      logic [19:0] lfsr;
      logic [2:0] code_cnt;
      logic bit_q;
   } gen_s;

   gen_s s_q;
   gen_s s_d;

   // Next state of sequence, counter and output bit
   always_comb begin
      logic fb;
      logic [2:0] len;
      fb = 1'b0;
      len = LOOP_UP_LEN;
      s_d = s_q;
      if (i_test_sel == TEST_LOOP_DOWN) begin
         len = LOOP_DOWN_LEN;
      end
      if (i_tick) begin
         // Taps differ by sequence length
         if (i_kind) begin
            fb = s_q.lfsr[QRSS_TAP_A] ^ s_q.lfsr[QRSS_TAP_B];
         end else begin
            fb = s_q.lfsr[PRBS_TAP_A] ^ s_q.lfsr[PRBS_TAP_B];
         end
         s_d.lfsr = {s_q.lfsr[18:0], fb};
         // Guard against the all-zero lock-up state
         if (s_d.lfsr == 20'h00000) begin
            s_d.lfsr = LFSR_SEED;
         end
         if (s_q.code_cnt >= len - 3'h1) begin
            s_d.code_cnt = 3'h0;
         end else begin
            s_d.code_cnt = s_q.code_cnt + 3'h1;
         end
         unique case (i_test_sel)
            TEST_RANDOM: s_d.bit_q = fb ^ i_invert;
            TEST_ONES: s_d.bit_q = 1'b1;
            TEST_LOOP_UP: s_d.bit_q = (s_q.code_cnt == LOOP_UP_LEN - 3'h1);
            TEST_LOOP_DOWN: s_d.bit_q = (s_q.code_cnt == LOOP_DOWN_LEN - 3'h1);
            default: s_d.bit_q = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q <= '{lfsr: LFSR_SEED, code_cnt: 3'h0, bit_q: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pattern_bit = s_q.bit_q;

endmodule // test_pattern_gen
`default_nettype wire

// ---- line_unit_ctrl.sv ----
/*
 Line unit control register bank with transmit test pattern insertion.
 Holds the three control registers and eight pulse segment registers,
 decodes them into line controls and steers transmit and receive data.
 Assumes an AHB-Lite master on i_core_clk and receive pins that are
 asynchronous to it.
*/
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module line_unit_ctrl #(
   parameter int BIT_DIVIDE = line_unit_pkg::BIT_DIV
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Transmit data from the framer, same clock
   input wire logic i_tx_pos,
   input wire logic i_tx_neg,
   output logic o_tx_line_pos,
   output logic o_tx_line_neg,
   // Receive pins, asynchronous
   input wire logic i_rx_line_pos,
   input wire logic i_rx_line_neg,
   input wire logic i_rx_clk,
   output logic o_rx_data_out,
   output logic o_rx_data_neg,
   output logic o_rx_clk_out,
   // Pulse segment lookup
   input wire logic [2:0] i_segment_index,
   output logic [7:0] o_pulse_segment,
   output logic o_arbitrary_pulse,
   // Line controls
   output logic o_receiver_power_on,
   output logic [4:0] o_equalizer_select,
   output logic o_e1_mode,
   output logic o_e1_coax,
   output logic o_rx_termination_en,
   output logic o_tx_termination_en,
   output logic [1:0] o_termination_impedance_sel,
   output logic o_rx_jitter_atten_en,
   output logic o_tx_jitter_atten_en,
   output logic o_jitter_low_bandwidth,
   output logic o_jitter_fifo_deep,
   output logic o_single_rail,
   output logic o_loop_detect_inhibit
);
   import line_unit_pkg::*;

   localparam logic [7:0] DIV_LAST = 8'(BIT_DIVIDE - 1);

   typedef struct packed {
      logic [7:0] ctrl_zero;
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [7:0][7:0] segment;
      logic wr_pend;
      logic [15:0] wr_idx;
      logic [7:0] rdata;
      logic [7:0] div_cnt;
      logic [2:0] rx_meta;
      logic [2:0] rx_sync;
      logic clk_tog;
      logic tx_pos;
      logic tx_neg;
      logic rx_data;
      logic rx_neg;
      logic rx_clk;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic tick;
   logic pattern_bit;
   logic [2:0] test_sel;
   logic random_on;
   logic to_receive;
   logic addr_phase;
   logic mapped;
   logic [15:0] idx;
   logic hit;

   // Field views of the control registers
   assign test_sel = s_q.ctrl_two[F2_TEST_MSB:F2_TEST_LSB];
   assign random_on = (test_sel == TEST_RANDOM);
   assign to_receive = random_on & s_q.ctrl_zero[F0_DIRECTION];
   assign tick = (s_q.div_cnt == DIV_LAST);

   // Bus address phase decode
   assign addr_phase = i_hsel & i_hready & i_htrans[1];
   assign idx = i_haddr[IDX_MSB:IDX_LSB];
   assign mapped = (i_haddr[31:IDX_MSB + 1] == 14'h0000) && (i_haddr[1:0] == 2'h0);
   // Only real registers take writes, so empty slots never forward data
   assign hit = mapped && (idx == IDX_CTRL_ZERO || idx == IDX_CTRL_ONE ||
      idx == IDX_CTRL_TWO || idx[15:3] == IDX_SEG_BASE[15:3]);

   // Register read multiplexer; unmapped reads return zero
   function automatic logic [7:0] read_reg(input state_s s, input logic [15:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a == IDX_CTRL_ZERO) begin
         r = s.ctrl_zero;
      end else if (a == IDX_CTRL_ONE) begin
         r = s.ctrl_one;
      end else if (a == IDX_CTRL_TWO) begin
         r = s.ctrl_two;
      end else if (a[15:3] == IDX_SEG_BASE[15:3]) begin
         r = s.segment[a[2:0]];
      end
      return r;
   endfunction

   // Whole next state: bus, divider, synchronisers and data paths
   always_comb begin
      s_d = s_q;

      // Data phase of a write commits the low byte
      if (s_q.wr_pend) begin
         if (s_q.wr_idx == IDX_CTRL_ZERO) begin
            s_d.ctrl_zero = i_hwdata[7:0];
         end else if (s_q.wr_idx == IDX_CTRL_ONE) begin
            s_d.ctrl_one = i_hwdata[7:0];
         end else if (s_q.wr_idx == IDX_CTRL_TWO) begin
            s_d.ctrl_two = i_hwdata[7:0];
         end else if (s_q.wr_idx[15:3] == IDX_SEG_BASE[15:3]) begin
            s_d.segment[s_q.wr_idx[2:0]] = i_hwdata[7:0];
         end
      end

      // Address phase: latch writes, capture reads with forwarding
      s_d.wr_pend = addr_phase & i_hwrite & hit;
      s_d.wr_idx = idx;
      if (addr_phase && !i_hwrite) begin
         if (!mapped) begin
            s_d.rdata = 8'h00;
         end else if (s_q.wr_pend && s_q.wr_idx == idx) begin
            // Back-to-back write then read of one register
            s_d.rdata = i_hwdata[7:0];
         end else begin
            s_d.rdata = read_reg(s_q, idx);
         end
      end

      // Line bit rate enable
      if (tick) begin
         s_d.div_cnt = 8'h00;
         s_d.clk_tog = ~s_q.clk_tog;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 8'h01;
      end

      // Two-flop synchronisers on receive pins
      s_d.rx_meta = {i_rx_clk, i_rx_line_neg, i_rx_line_pos};
      s_d.rx_sync = s_q.rx_meta;

      // Transmit path: test pattern replaces framer data as single rail
      if (test_sel[2] && !to_receive) begin
         s_d.tx_pos = pattern_bit;
         s_d.tx_neg = 1'b0;
      end else begin
         // Normal data, also for reserved codes
         s_d.tx_pos = i_tx_pos;
         s_d.tx_neg = i_tx_neg;
      end

      // Receive path: generator, live data, or powered down
      if (to_receive) begin
         s_d.rx_data = pattern_bit;
         s_d.rx_neg = 1'b0;
         s_d.rx_clk = s_q.clk_tog;
      end else if (s_q.ctrl_zero[F0_RX_ON]) begin
         s_d.rx_data = s_q.rx_sync[0];
         s_d.rx_neg = s_q.rx_sync[1];
         s_d.rx_clk = s_q.rx_sync[2];
      end else begin
         // Receive section held quiet while off
         s_d.rx_data = 1'b0;
         s_d.rx_neg = 1'b0;
         s_d.rx_clk = 1'b0;
      end
   end

   // State register; every control field starts cleared
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q.ctrl_zero <= RST_CTRL_ZERO;
         s_q.ctrl_one <= RST_CTRL_ONE;
         s_q.ctrl_two <= RST_CTRL_TWO;
         s_q.segment <= {8{RST_SEGMENT}};
         s_q.wr_pend <= 1'b0;
         s_q.wr_idx <= 16'h0000;
         s_q.rdata <= 8'h00;
         s_q.div_cnt <= 8'h00;
         s_q.rx_meta <= 3'h0;
         s_q.rx_sync <= 3'h0;
         s_q.clk_tog <= 1'b0;
         s_q.tx_pos <= 1'b0;
         s_q.tx_neg <= 1'b0;
         s_q.rx_data <= 1'b0;
         s_q.rx_neg <= 1'b0;
         s_q.rx_clk <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Pattern source for both directions
   test_pattern_gen u_pattern (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_tick(tick),
      .i_test_sel(test_sel),
      .i_kind(s_q.ctrl_zero[F0_KIND]),
      .i_invert(s_q.ctrl_two[F2_INVERT]),
      .o_pattern_bit(pattern_bit)
   );

   // Bus answer: zero wait states, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = {24'h000000, s_q.rdata};

   // Registered line data
   assign o_tx_line_pos = s_q.tx_pos;
   assign o_tx_line_neg = s_q.tx_neg;
   assign o_rx_data_out = s_q.rx_data;
   assign o_rx_data_neg = s_q.rx_neg;
   assign o_rx_clk_out = s_q.rx_clk;

   // Equalizer decode; arbitrary pulse codes use segment registers
   assign o_equalizer_select = s_q.ctrl_zero[F0_EQ_MSB:F0_EQ_LSB];
   assign o_e1_mode = (o_equalizer_select >= EQ_FIRST_E1);
   assign o_e1_coax = o_e1_mode & ~o_equalizer_select[0];
   assign o_arbitrary_pulse = (o_equalizer_select == EQ_T1_SH_ARB) ||
      (o_equalizer_select == EQ_T1_GAIN_ARB);
   assign o_pulse_segment = s_q.segment[i_segment_index];

   // Receive power and termination
   assign o_receiver_power_on = s_q.ctrl_zero[F0_RX_ON];
   assign o_rx_termination_en = s_q.ctrl_one[F1_RX_TERM];
   assign o_tx_termination_en = s_q.ctrl_one[F1_TX_TERM];
   assign o_termination_impedance_sel = s_q.ctrl_one[F1_IMP_MSB:F1_IMP_LSB];

   // Jitter attenuator placement and FIFO depth
   assign o_rx_jitter_atten_en = s_q.ctrl_one[F1_RX_JA];
   assign o_tx_jitter_atten_en = s_q.ctrl_one[F1_TX_JA];
   assign o_jitter_low_bandwidth = s_q.ctrl_one[F1_JA_BW];
   // Low bandwidth needs the deep FIFO regardless of the size bit
   assign o_jitter_fifo_deep = s_q.ctrl_one[F1_JA_BW] | s_q.ctrl_one[F1_FIFO_SIZE];

   // Test modes force single rail; own loop-up must not trigger loop-back
   assign o_single_rail = test_sel[2];
   assign o_loop_detect_inhibit = (test_sel == TEST_LOOP_UP);

endmodule // line_unit_ctrl
`default_nettype wire

// ---- line_unit_ctrl_monitor.sv ----
/*
 Checker for the line unit control bank, bound to its top ports.
 Assumes one core clock domain and an active low async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module line_unit_ctrl_monitor #(
   parameter int BIT_DIVIDE = 5
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_tx_pos,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_tx_line_pos,
   input wire logic o_rx_data_out,
   input wire logic o_rx_data_neg,
   input wire logic o_arbitrary_pulse,
   input wire logic o_receiver_power_on,
   input wire logic [4:0] o_equalizer_select,
   input wire logic o_e1_mode,
   input wire logic o_e1_coax,
   input wire logic o_jitter_low_bandwidth,
   input wire logic o_jitter_fifo_deep,
   input wire logic o_single_rail,
   input wire logic o_loop_detect_inhibit
);
   // Loop-up code repeats every five line bits
   localparam int UP_GAP = 5 * BIT_DIVIDE;
   localparam int SETTLE = BIT_DIVIDE + 2;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or not okay");
   a_e1_range: assert property (o_e1_mode == (o_equalizer_select >= 5'h18))
      else $error("e1 decode wrong");
   a_coax_pick: assert property (o_e1_coax == (o_e1_mode && !o_equalizer_select[0]))
      else $error("coax decode wrong");
   a_arb_pulse: assert property (o_arbitrary_pulse ==
      (o_equalizer_select == 5'h0D || o_equalizer_select == 5'h13))
      else $error("arbitrary pulse decode wrong");
   a_fifo_forced: assert property (o_jitter_low_bandwidth |-> o_jitter_fifo_deep)
      else $error("low bandwidth without deep fifo");
   a_inhibit_rail: assert property (o_loop_detect_inhibit |-> o_single_rail)
      else $error("loop-up without single rail");
   // Normal mode passes framer data with one cycle of latency
   a_tx_passthru: assert property ($past(i_reset_n) && !o_single_rail
      && !$past(o_single_rail) |-> o_tx_line_pos == $past(i_tx_pos))
      else $error("framer data not passed");
   a_rx_quiet: assert property (!o_receiver_power_on && !$past(o_receiver_power_on)
      |-> !o_rx_data_out && !o_rx_data_neg)
      else $error("receiver off but outputs active");
   // Waiting a settle time skips a partial first bit after entry
   a_up_single: assert property (o_loop_detect_inhibit && $rose(o_tx_line_pos)
      && $past(o_loop_detect_inhibit, SETTLE)
      |-> ##BIT_DIVIDE (!o_tx_line_pos || !o_loop_detect_inhibit))
      else $error("loop-up one too long");
   a_up_period: assert property (o_loop_detect_inhibit && $rose(o_tx_line_pos)
      && $past(o_loop_detect_inhibit, SETTLE)
      |-> ##UP_GAP (o_tx_line_pos || !o_loop_detect_inhibit))
      else $error("loop-up period wrong");
endmodule // line_unit_ctrl_monitor

bind line_unit_ctrl line_unit_ctrl_monitor #(.BIT_DIVIDE(BIT_DIVIDE)) i_line_unit_ctrl_monitor (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_tx_pos(i_tx_pos),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_tx_line_pos(o_tx_line_pos),
   .o_rx_data_out(o_rx_data_out), .o_rx_data_neg(o_rx_data_neg),
   .o_arbitrary_pulse(o_arbitrary_pulse), .o_receiver_power_on(o_receiver_power_on),
   .o_equalizer_select(o_equalizer_select), .o_e1_mode(o_e1_mode), .o_e1_coax(o_e1_coax),
   .o_jitter_low_bandwidth(o_jitter_low_bandwidth), .o_jitter_fifo_deep(o_jitter_fifo_deep),
   .o_single_rail(o_single_rail), .o_loop_detect_inhibit(o_loop_detect_inhibit));
`default_nettype wire

// ---- line_far_end_model.sv ----
/*
 Far side model: framer dual rail transmit data and receive line pins.
 Assumes the bench gives the receive level; pins move after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module line_far_end_model (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_rx_level,
   output logic o_tx_pos,
   output logic o_tx_neg,
   output logic o_rx_pos,
   output logic o_rx_neg,
   output logic o_rx_clk
);
   logic [1:0] phase_q;
   // Free running phase; rails never both high, as a real framer
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end
   assign o_tx_pos = (phase_q == 2'h1);
   assign o_tx_neg = (phase_q == 2'h3);
   assign o_rx_pos = i_rx_level;
   assign o_rx_neg = !i_rx_level;
   assign o_rx_clk = phase_q[0];
endmodule // line_far_end_model
`default_nettype wire

// ---- line_unit_test_pattern_control_tb.sv ----
/*
 Bench for the line unit control bank: AHB-Lite register tasks and
 pattern checks on the line. Assumes a single slave answering OKAY.
*/
`timescale 1ns/1ps
`default_nettype none
module line_unit_test_pattern_control_tb;
   import line_unit_pkg::*;
   localparam int BD = 5;
   localparam logic [31:0] A_ZERO = {14'h0, IDX_CTRL_ZERO, 2'b00};
   localparam logic [31:0] A_ONE = {14'h0, IDX_CTRL_ONE, 2'b00};
   localparam logic [31:0] A_TWO = {14'h0, IDX_CTRL_TWO, 2'b00};
   localparam logic [31:0] A_SEG = {14'h0, IDX_SEG_BASE, 2'b00};
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_level = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, imp;
   logic [2:0] seg_idx = 3'h0;
   logic [4:0] eq;
   logic [7:0] seg;
   logic rdy, resp, tx_lp, tx_ln, rx_do, rx_dn, rx_co, arb, rx_on, e1, coax, rx_t, tx_t;
   logic ja_r, ja_t, ja_bw, ja_deep, s_rail, inhib, tx_p, tx_n, rx_p, rx_n, rx_c;
   logic bits [40];
   int n_fail = 0;
   int tests_run = 0;

   always #50 clk = ~clk;

   line_unit_ctrl #(.BIT_DIVIDE(BD)) i_line_unit_ctrl (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata),
      .i_tx_pos(tx_p), .i_tx_neg(tx_n), .o_tx_line_pos(tx_lp), .o_tx_line_neg(tx_ln),
      .i_rx_line_pos(rx_p), .i_rx_line_neg(rx_n), .i_rx_clk(rx_c), .o_rx_data_out(rx_do),
      .o_rx_data_neg(rx_dn), .o_rx_clk_out(rx_co), .i_segment_index(seg_idx),
      .o_pulse_segment(seg), .o_arbitrary_pulse(arb), .o_receiver_power_on(rx_on),
      .o_equalizer_select(eq), .o_e1_mode(e1), .o_e1_coax(coax), .o_rx_termination_en(rx_t),
      .o_tx_termination_en(tx_t), .o_termination_impedance_sel(imp),
      .o_rx_jitter_atten_en(ja_r), .o_tx_jitter_atten_en(ja_t),
      .o_jitter_low_bandwidth(ja_bw), .o_jitter_fifo_deep(ja_deep),
      .o_single_rail(s_rail), .o_loop_detect_inhibit(inhib));

   line_far_end_model i_line_far_end_model (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_rx_level(rx_level), .o_tx_pos(tx_p),
      .o_tx_neg(tx_n), .o_rx_pos(rx_p), .o_rx_neg(rx_n), .o_rx_clk(rx_c));

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int n;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (rdy === 1'b1) break;
      end
      if (n == 16) begin
         n_fail++;
         tally_and_finish();
      end
   endtask

   task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   // Read data is taken at the data phase's closing edge
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      ahb(a, 1'b0, 32'h0);
      chk(hrdata, exp);
      chk(resp, 1'b0);
   endtask

   // One sample per line bit, after the new mode has settled
   task automatic grab(input logic rx_side);
      int k;
      repeat (4 * BD) @(negedge clk);
      for (k = 0; k < 40; k++) begin
         repeat (BD) @(negedge clk);
         bits[k] = rx_side ? rx_do : tx_lp;
      end
   endtask

   // Output-fed shift register: bit k xored with two earlier bits gives the invert flag
   task automatic chk_lfsr(input int la, input int lb, input logic inv);
      int k;
      for (k = 20; k < 40; k++) chk(bits[k] ^ bits[k - la] ^ bits[k - lb], inv);
   endtask

   task automatic chk_pass;
      logic [1:0] p;
      repeat (8) begin
         @(negedge clk);
         p = {tx_p, tx_n};
         @(negedge clk);
         chk({tx_lp, tx_ln}, p);
      end
   endtask

   initial begin
      int i;
      int k;
      int s;
      logic c;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(A_ZERO, 32'h0);
      rd_chk(A_ONE, 32'h0);
      rd_chk(A_TWO, 32'h0);
      rd_chk(A_SEG, 32'h0);
      chk({rx_t, s_rail, rx_on}, 3'h0);
      ahb(A_ONE, 1'b1, 32'hFFFF_FFB6);
      rd_chk(A_ONE, 32'h0000_00B6);
      chk({rx_t, tx_t, imp, ja_r, ja_t, ja_bw, ja_deep}, 8'hB7);
      for (i = 0; i < 4; i++) begin
         ahb(A_ONE, 1'b1, i);
         @(negedge clk);
         chk({ja_bw, ja_deep}, {i[1], i[1] | i[0]});
      end
      // Unmapped and misaligned places read as zero
      ahb(32'h0000_3C10, 1'b1, 32'h0000_005A);
      rd_chk(32'h0000_3C10, 32'h0);
      rd_chk(A_ONE + 32'h1, 32'h0);
      for (i = 0; i < 8; i++) ahb(A_SEG + 4 * i, 1'b1, i * 17 + 3);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         seg_idx <= i[2:0];
         @(negedge clk);
         chk(seg, i * 17 + 3);
      end
      for (i = 0; i < 32; i++) begin
         ahb(A_ZERO, 1'b1, 32'h20 | i);
         rd_chk(A_ZERO, 32'h20 | i);
         chk({rx_on, e1, coax, arb, eq}, {1'b1, i >= 24, i >= 24 && !i[0],
            i == 13 || i == 19, i[4:0]});
      end
      // Receiver on follows the pins, off stays quiet
      ahb(A_ZERO, 1'b1, 32'h20);
      for (i = 0; i < 3; i++) begin
         if (i == 2) ahb(A_ZERO, 1'b1, 32'h0);
         @(posedge clk);
         rx_level <= !i[0];
         repeat (6) @(negedge clk);
         chk({rx_do, rx_dn}, i == 2 ? 2'b00 : {!i[0], i[0]});
      end
      ahb(A_ZERO, 1'b1, 32'h20);
      ahb(A_TWO, 1'b1, 32'h30);
      chk(s_rail, 1'b0);
      chk_pass();
      ahb(A_TWO, 1'b1, 32'h50);
      repeat (2 * BD) @(negedge clk);
      chk({tx_lp, tx_ln, s_rail, inhib}, 4'hA);
      for (i = 0; i < 2; i++) begin
         ahb(A_TWO, 1'b1, i ? 32'h70 : 32'h60);
         grab(1'b0);
         s = 0;
         for (k = 0; k < 30; k++) s += bits[k];
         chk(s, i ? 10 : 6);
         for (k = 5; k < 40; k++) chk(bits[k] ^ bits[k - (i ? 3 : 5)], 0);
         chk(inhib, !i);
      end
      for (i = 0; i < 4; i++) begin
         ahb(A_ZERO, 1'b1, {i[1], 7'h20});
         ahb(A_TWO, 1'b1, {i[0], 7'h40});
         grab(1'b0);
         chk_lfsr(i[1] ? 20 : 15, i[1] ? 17 : 14, i[0]);
      end
      ahb(A_ZERO, 1'b1, 32'h60);
      ahb(A_TWO, 1'b1, 32'h40);
      grab(1'b1);
      chk_lfsr(15, 14, 1'b0);
      chk_pass();
      // Receive clock out flips once per line bit while the generator feeds it
      repeat (4) begin
         c = rx_co;
         repeat (BD) @(negedge clk);
         chk(rx_co ^ c, 1'b1);
      end
      tally_and_finish();
   end
endmodule // line_unit_test_pattern_control_tb
`default_nettype wire
